// File: adcsq_pkg.sv
// adcsq_pkg: constants, types and register map of the converter control block
// assumes an 8-bit register port with one-cycle read latency on a single clock
package adcsq_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [4:0] ADCSQ_OFF_SAMP = 5'h05;
    localparam logic [4:0] ADCSQ_OFF_PLUS = 5'h08;
    localparam logic [4:0] ADCSQ_OFF_MINUS = 5'h09;
    localparam logic [4:0] ADCSQ_OFF_CMD = 5'h0A;
    localparam logic [4:0] ADCSQ_OFF_EVT = 5'h0B;
    localparam logic [4:0] ADCSQ_OFF_IEN = 5'h0C;
    localparam logic [4:0] ADCSQ_OFF_FLAG = 5'h0D;
    localparam logic [4:0] ADCSQ_OFF_HALT = 5'h0E;
    localparam logic [4:0] ADCSQ_OFF_LATCH = 5'h0F;
    localparam logic [4:0] ADCSQ_OFF_VALL = 5'h10;
    localparam logic [4:0] ADCSQ_OFF_VALH = 5'h11;
    // mode register and window bounds, placed in free offsets
    localparam logic [4:0] ADCSQ_OFF_MODE = 5'h18;
    localparam logic [4:0] ADCSQ_OFF_LOWL = 5'h12;
    localparam logic [4:0] ADCSQ_OFF_HIGHL = 5'h14;
    // ****************************************
    // field positions and reset value
    // ****************************************
    localparam int ADCSQ_BIT_START = 0;
    localparam int ADCSQ_BIT_STOP = 1;
    localparam int ADCSQ_BIT_READY = 0;
    localparam int ADCSQ_BIT_WIN = 1;
    localparam int ADCSQ_BIT_CONT = 0;
    localparam logic [7:0] ADCSQ_RST8 = 8'h00;
    // ****************************************
    // timing
    // ****************************************
    localparam logic [8:0] ADCSQ_BASE_SAMP = 9'h002; // converter cycles
    localparam logic [3:0] ADCSQ_CONV_CYC = 4'hC; // conversion phase, converter cycles
    // ****************************************
    // selector codes
    // ****************************************
    localparam logic [6:0] ADCSQ_SEL_GND = 7'h40;
    localparam logic [6:0] ADCSQ_SEL_THERM = 7'h42;
    localparam logic [6:0] ADCSQ_SEL_CONVOUT = 7'h48;
    localparam logic [6:0] ADCSQ_SEL_REF_LO = 7'h49;
    localparam logic [6:0] ADCSQ_SEL_REF_HI = 7'h4B;
    localparam logic [6:0] ADCSQ_PLUS_PIN_MAX = 7'h15;
    localparam logic [6:0] ADCSQ_MINUS_PIN_MAX = 7'h0F;
    // window modes
    localparam logic [2:0] ADCSQ_WIN_NONE = 3'h0;
    localparam logic [2:0] ADCSQ_WIN_BELOW = 3'h1;
    localparam logic [2:0] ADCSQ_WIN_ABOVE = 3'h2;
    localparam logic [2:0] ADCSQ_WIN_INSIDE = 3'h3;
    localparam logic [2:0] ADCSQ_WIN_OUTSIDE = 3'h4;

    // conversion sequencer states
    typedef enum logic [2:0] {
        ADCSQ_IDLE = 3'b001,
        ADCSQ_SAMPLE = 3'b010,
        ADCSQ_CONVERT = 3'b100
    } adcsq_state_e;

    // register port request
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcsq_bus_s;

    // analog front-end selection
    typedef struct packed {
        logic [6:0] plus_sel;
        logic [6:0] minus_sel;
        logic plus_valid;
        logic minus_valid;
    } adcsq_mux_s;

    // whole block state
    typedef struct packed {
        adcsq_state_e st;
        logic [8:0] cnt;
        logic [7:0] samp_ext;
        logic [6:0] plus_sel;
        logic [6:0] minus_sel;
        adcsq_mux_s mux;
        logic pend;
        logic busy;
        logic cont;
        logic [2:0] win_mode;
        logic [15:0] low_bound;
        logic [15:0] high_bound;
        logic trig_en;
        logic [1:0] ien;
        logic [1:0] flags;
        logic halt_bypass;
        logic [7:0] latch;
        logic [15:0] value;
        logic [7:0] rdata;
        logic irq;
        logic conv_active;
        logic [2:0] ev_sync;
        logic ev_prev;
        logic [2:0] halt_sync;
    } adcsq_state_s;
endpackage : adcsq_pkg

// File: adcsq_top.sv
// adcsq_top: register file and conversion sequencer of the converter
// assumes a converter clock enable tick, an asynchronous event and halt pin,
// and an analog core that returns a 16-bit sample when asked
`timescale 1ns/100ps
module adcsq_top
    import adcsq_pkg::*;
(
    input wire logic clk, // 100 MHz peripheral clock
    input wire logic rstn, // synchronous, active low
    input wire adcsq_bus_s bus, // register port request
    input wire logic conv_tick, // one-cycle converter clock tick
    input wire logic event_in, // asynchronous start event
    input wire logic cpu_halted, // asynchronous debug halt
    input wire logic [15:0] sample_data, // analog core result
    output logic [7:0] rdata, // read data, one cycle after read strobe
    output logic irq, // interrupt request
    output logic conv_active, // sequencer is sampling or converting
    output adcsq_mux_s mux // applied input selection
);
    adcsq_state_s s_r; // all state
    adcsq_state_s s_nxt; // next state
    logic run; // converter may advance
    logic ev_rise; // filtered event edge
    logic win_hit; // window comparison result
    logic plus_ok; // plus code decodes
    logic minus_ok; // minus code decodes
    logic wr_one_start; // start written one
    logic wr_one_stop; // stop written one
    logic done; // conversion finishes now

    // ****************************************
    // decode and comparison
    // ****************************************
    // legal selector codes
    always_comb begin
        plus_ok = (s_r.plus_sel <= ADCSQ_PLUS_PIN_MAX) || (s_r.plus_sel == ADCSQ_SEL_GND)
            || (s_r.plus_sel == ADCSQ_SEL_THERM) || (s_r.plus_sel == ADCSQ_SEL_CONVOUT)
            || ((s_r.plus_sel >= ADCSQ_SEL_REF_LO) && (s_r.plus_sel <= ADCSQ_SEL_REF_HI));
        minus_ok = (s_r.minus_sel <= ADCSQ_MINUS_PIN_MAX) || (s_r.minus_sel == ADCSQ_SEL_GND)
            || (s_r.minus_sel == ADCSQ_SEL_CONVOUT);
    end

    // window mode compare on the fresh sample
    always_comb begin
        case (s_r.win_mode)
            ADCSQ_WIN_BELOW: begin
                win_hit = sample_data < s_r.low_bound;
            end
            ADCSQ_WIN_ABOVE: begin
                win_hit = sample_data > s_r.high_bound;
            end
            ADCSQ_WIN_INSIDE: begin
                win_hit = (sample_data >= s_r.low_bound) && (sample_data <= s_r.high_bound);
            end
            ADCSQ_WIN_OUTSIDE: begin
                win_hit = (sample_data < s_r.low_bound) || (sample_data > s_r.high_bound);
            end
            default: begin
                win_hit = 1'b0; // none and reserved codes
            end
        endcase
    end

    // pin filters and strobes
    always_comb begin
        // converter halts with the cpu unless bypass is set
        run = conv_tick && (!(s_r.halt_sync[2] && s_r.halt_sync[1]) || s_r.halt_bypass);
        // a rise counts once stages two and three agree
        ev_rise = s_r.ev_sync[1] && s_r.ev_sync[2] && !s_r.ev_prev && s_r.trig_en;
        wr_one_start = bus.wr && (bus.addr == ADCSQ_OFF_CMD) && bus.wdata[ADCSQ_BIT_START];
        wr_one_stop = bus.wr && (bus.addr == ADCSQ_OFF_CMD) && bus.wdata[ADCSQ_BIT_STOP];
        done = run && (s_r.st == ADCSQ_CONVERT) && (s_r.cnt == 9'h000) && !wr_one_stop;
    end

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.ev_sync = {s_r.ev_sync[1:0], event_in};
        s_nxt.halt_sync = {s_r.halt_sync[1:0], cpu_halted};
        if (s_r.ev_sync[1] == s_r.ev_sync[2]) begin
            s_nxt.ev_prev = s_r.ev_sync[2];
        end
        s_nxt.rdata = ADCSQ_RST8;
        // register writes
        if (bus.wr) begin
            case (bus.addr)
                ADCSQ_OFF_SAMP: s_nxt.samp_ext = bus.wdata;
                ADCSQ_OFF_PLUS: s_nxt.plus_sel = bus.wdata[6:0];
                ADCSQ_OFF_MINUS: s_nxt.minus_sel = bus.wdata[6:0];
                ADCSQ_OFF_EVT: s_nxt.trig_en = bus.wdata[0];
                ADCSQ_OFF_IEN: s_nxt.ien = bus.wdata[1:0];
                ADCSQ_OFF_FLAG: s_nxt.flags = s_r.flags & ~bus.wdata[1:0];
                ADCSQ_OFF_HALT: s_nxt.halt_bypass = bus.wdata[0];
                ADCSQ_OFF_LATCH: s_nxt.latch = bus.wdata;
                ADCSQ_OFF_MODE: begin
                    s_nxt.cont = bus.wdata[ADCSQ_BIT_CONT];
                    s_nxt.win_mode = bus.wdata[6:4];
                end
                // 16-bit bounds: low byte parks in the latch, high byte commits both
                ADCSQ_OFF_LOWL: s_nxt.latch = bus.wdata;
                ADCSQ_OFF_LOWL + 5'h01: s_nxt.low_bound = {bus.wdata, s_r.latch};
                ADCSQ_OFF_HIGHL: s_nxt.latch = bus.wdata;
                ADCSQ_OFF_HIGHL + 5'h01: s_nxt.high_bound = {bus.wdata, s_r.latch};
                default: ; // command handled below, others ignored
            endcase
        end
        // register reads
        if (bus.rd) begin
            case (bus.addr)
                ADCSQ_OFF_SAMP: s_nxt.rdata = s_r.samp_ext;
                ADCSQ_OFF_PLUS: s_nxt.rdata = {1'b0, s_r.plus_sel};
                ADCSQ_OFF_MINUS: s_nxt.rdata = {1'b0, s_r.minus_sel};
                ADCSQ_OFF_CMD: s_nxt.rdata = {7'h00, s_r.busy};
                ADCSQ_OFF_EVT: s_nxt.rdata = {7'h00, s_r.trig_en};
                ADCSQ_OFF_IEN: s_nxt.rdata = {6'h00, s_r.ien};
                ADCSQ_OFF_FLAG: s_nxt.rdata = {6'h00, s_r.flags};
                ADCSQ_OFF_HALT: s_nxt.rdata = {7'h00, s_r.halt_bypass};
                ADCSQ_OFF_LATCH: s_nxt.rdata = s_r.latch;
                ADCSQ_OFF_MODE: s_nxt.rdata = {1'b0, s_r.win_mode, 3'h0, s_r.cont};
                ADCSQ_OFF_VALL: begin
                    s_nxt.rdata = s_r.value[7:0];
                    s_nxt.latch = s_r.value[15:8];
                    s_nxt.flags = 2'b00;
                end
                ADCSQ_OFF_VALH: begin
                    s_nxt.rdata = s_r.latch;
                    s_nxt.flags = 2'b00;
                end
                default: s_nxt.rdata = ADCSQ_RST8; // unmapped reads zero
            endcase
        end
        // start request queues behind a running conversion
        if (wr_one_start || ev_rise) begin
            s_nxt.pend = 1'b1;
            s_nxt.busy = 1'b1;
        end
        // sequencer
        case (s_r.st)
            ADCSQ_IDLE: begin
                // no conversion running: a new selection applies at once
                s_nxt.mux = '{s_r.plus_sel, s_r.minus_sel, plus_ok, minus_ok};
                if (s_r.pend && run) begin
                    s_nxt.st = ADCSQ_SAMPLE;
                    s_nxt.pend = wr_one_start || ev_rise;
                    s_nxt.mux = '{s_r.plus_sel, s_r.minus_sel, plus_ok, minus_ok};
                    // two base cycles plus the extension; the zero count is the last one
                    s_nxt.cnt = ADCSQ_BASE_SAMP + {1'b0, s_r.samp_ext} - 9'h001;
                end
            end
            ADCSQ_SAMPLE: begin
                if (run) begin
                    if (s_r.cnt == 9'h000) begin
                        s_nxt.st = ADCSQ_CONVERT;
                        s_nxt.cnt = {5'h00, ADCSQ_CONV_CYC} - 9'h001;
                    end else begin
                        s_nxt.cnt = s_r.cnt - 9'h001;
                    end
                end
            end
            ADCSQ_CONVERT: begin
                if (done) begin
                    s_nxt.value = sample_data;
                    s_nxt.mux = '{s_r.plus_sel, s_r.minus_sel, plus_ok, minus_ok};
                    s_nxt.flags[ADCSQ_BIT_READY] = 1'b1;
                    if (win_hit) begin
                        s_nxt.flags[ADCSQ_BIT_WIN] = 1'b1;
                    end
                    if (s_r.cont) begin
                        s_nxt.st = ADCSQ_SAMPLE;
                        s_nxt.cnt = ADCSQ_BASE_SAMP + {1'b0, s_r.samp_ext} - 9'h001;
                    end else if (s_r.pend || wr_one_start || ev_rise) begin
                        s_nxt.st = ADCSQ_IDLE;
                        s_nxt.busy = 1'b1;
                    end else begin
                        s_nxt.st = ADCSQ_IDLE;
                        s_nxt.busy = 1'b0;
                    end
                end else if (run) begin
                    s_nxt.cnt = s_r.cnt - 9'h001;
                end
            end
            default: begin
                s_nxt.st = ADCSQ_IDLE;
            end
        endcase
        // stop overrides everything, including a start in the same write
        if (wr_one_stop) begin
            s_nxt.st = ADCSQ_IDLE;
            s_nxt.pend = 1'b0;
            s_nxt.busy = 1'b0;
        end
        // zero bits of a command write fall through untouched
        s_nxt.conv_active = (s_nxt.st != ADCSQ_IDLE);
        s_nxt.irq = |(s_nxt.flags & s_nxt.ien);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.st <= ADCSQ_IDLE; // state resets to idle, code 3'b001 rather than zero
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign irq = s_r.irq;
    assign conv_active = s_r.conv_active;
    assign mux = s_r.mux;

    // ****************************************
    // assertions
    // ****************************************
    stop_wins_a: assert property (@(posedge clk) disable iff (!rstn)
        (bus.wr && bus.addr == ADCSQ_OFF_CMD && bus.wdata[1]) |=> (s_r.st == ADCSQ_IDLE && !s_r.busy))
        else $error("stop did not end conversion");
    busy_read_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.st != ADCSQ_IDLE) |-> s_r.busy)
        else $error("start bit low during conversion");
    ready_set_a: assert property (@(posedge clk) disable iff (!rstn)
        done |=> s_r.flags[0])
        else $error("value ready not set");
    read_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (bus.rd && bus.addr == ADCSQ_OFF_VALL && !done) |=> s_r.flags == 2'b00)
        else $error("flags not cleared by value read");
    zero_write_a: assert property (@(posedge clk) disable iff (!rstn)
        (bus.wr && bus.addr == ADCSQ_OFF_FLAG && bus.wdata[1:0] == 2'b00 && !bus.rd && !done)
        |=> s_r.flags == $past(s_r.flags))
        else $error("zero write changed flags");
    irq_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        irq == |(s_r.flags & s_r.ien))
        else $error("irq disagrees with flags");
    latch_high_a: assert property (@(posedge clk) disable iff (!rstn)
        (bus.rd && bus.addr == ADCSQ_OFF_VALL) |=> s_r.latch == $past(s_r.value[15:8]))
        else $error("high byte not latched");
    mux_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.st == ADCSQ_SAMPLE && $past(s_r.st) == ADCSQ_SAMPLE) |-> $stable(s_r.mux))
        else $error("selection changed mid conversion");
endmodule // adcsq_top

// File: adc_sequencing_and_flags_test.sv
// adc_sequencing_and_flags_test: self-checking bench for the converter control block
// assumes adcsq_pkg and adcsq_top are compiled first; single 100 MHz clock
`timescale 1ns/100ps
module adc_sequencing_and_flags_test;
    import adcsq_pkg::*;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic clk = 1'b0; // peripheral clock
    logic rstn = 1'b0; // synchronous reset, active low
    adcsq_bus_s bus = '0; // register port request
    logic conv_tick = 1'b0; // converter tick, every other cycle
    logic event_in = 1'b0; // start event line
    logic cpu_halted = 1'b0; // debug halt level
    logic [15:0] sample_data = 16'h0000; // analog core result
    logic [7:0] rdata; // read data
    logic irq; // interrupt request
    logic conv_active; // sequencer busy
    adcsq_mux_s mux; // applied selection
    int failures = 0; // mismatch count
    int total_checks = 0; // comparison count
    int cycles = 0; // timeout counter
    int ticks = 0; // converter ticks seen while active
    logic [7:0] d; // last read value
    // selector decode table: code and expected validity
    logic [6:0] pc [9] = '{7'h00, 7'h15, 7'h16, 7'h40, 7'h41, 7'h42, 7'h48, 7'h4B, 7'h4C};
    logic [8:0] pv = 9'b011101011; // entry 0 is the lsb
    logic [6:0] mc [9] = '{7'h00, 7'h0F, 7'h10, 7'h40, 7'h41, 7'h48, 7'h49, 7'h3F, 7'h42};
    logic [8:0] mv = 9'b000101011;
    logic [15:0] smp [4] = '{16'h0FFF, 16'h1000, 16'h2000, 16'h2001}; // window edge samples

    adcsq_top dut (.clk(clk), .rstn(rstn), .bus(bus), .conv_tick(conv_tick),
        .event_in(event_in), .cpu_halted(cpu_halted), .sample_data(sample_data),
        .rdata(rdata), .irq(irq), .conv_active(conv_active), .mux(mux));

    // clock generator
    always #5 clk = ~clk;

    // tick source, tick counter and hang guard
    always @(posedge clk) begin
        conv_tick <= ~conv_tick;
        if (conv_active === 1'b1 && conv_tick === 1'b1) ticks++;
        cycles++;
        if (cycles == 30000) begin
            failures++;
            test_done();
        end
    end
    // ****************************************
    // bus and check tasks
    // ****************************************
    // compare and report
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    // bounded wait for the busy level
    task automatic wait_on(input logic v, input int lim, input string what);
        int n;
        n = 0;
        while (conv_active !== v && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        chk(conv_active, v, what);
    endtask
    // full conversion with a given core sample
    task automatic conv(input logic [15:0] s);
        @(posedge clk);
        sample_data <= s;
        wr(ADCSQ_OFF_CMD, 8'h01);
        wait_on(1'b1, 10, "start");
        wait_on(1'b0, 100, "finish");
    endtask
    // window match as the mode table defines it, bounds 1000..2000
    function automatic logic win_exp(input int m, input logic [15:0] s);
        case (m)
            1: return s < 16'h1000;
            2: return s > 16'h2000;
            3: return s >= 16'h1000 && s <= 16'h2000;
            4: return s < 16'h1000 || s > 16'h2000;
            default: return 1'b0;
        endcase
    endfunction
    // verdict and end of run
    task automatic test_done();
        if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        // reset values of offsets 5 to 17, unmapped places included, mode register not read
        for (int a = 5; a <= 17; a++) begin
            rd(a[4:0], d);
            chk(d, 16'h0000, "reset value");
        end
        rd(5'h1F, d);
        chk(d, 16'h0000, "unmapped read");
        // read/write storage, reserved top bit of the plus selector reads zero
        wr(ADCSQ_OFF_SAMP, 8'hA5);
        rd(ADCSQ_OFF_SAMP, d);
        chk(d, 16'h00A5, "sample extension");
        wr(ADCSQ_OFF_IEN, 8'h03);
        rd(ADCSQ_OFF_IEN, d);
        chk(d, 16'h0003, "irq enables");
        wr(ADCSQ_OFF_HALT, 8'h01);
        rd(ADCSQ_OFF_HALT, d);
        chk(d, 16'h0001, "halt bypass");
        wr(ADCSQ_OFF_EVT, 8'h01);
        rd(ADCSQ_OFF_EVT, d);
        chk(d, 16'h0001, "event enable");
        wr(ADCSQ_OFF_LATCH, 8'h5A);
        rd(ADCSQ_OFF_LATCH, d);
        chk(d, 16'h005A, "shared latch");
        wr(ADCSQ_OFF_PLUS, 8'hFF);
        rd(ADCSQ_OFF_PLUS, d);
        chk(d, 16'h007F, "plus select");
        // selector decode while idle
        for (int i = 0; i < 9; i++) begin
            wr(ADCSQ_OFF_PLUS, {1'b0, pc[i]});
            wr(ADCSQ_OFF_MINUS, {1'b0, mc[i]});
            repeat (2) @(posedge clk);
            #1 chk({mux.plus_sel, mux.plus_valid}, {8'h00, pc[i], pv[i]}, "plus decode");
            chk({mux.minus_sel, mux.minus_valid}, {8'h00, mc[i], mv[i]}, "minus decode");
        end
        wr(ADCSQ_OFF_PLUS, 8'h03);
        wr(ADCSQ_OFF_EVT, 8'h00);
        wr(ADCSQ_OFF_HALT, 8'h00);
        wr(ADCSQ_OFF_IEN, 8'h01);
        wr(ADCSQ_OFF_SAMP, 8'h00);
        // plain conversion, selector change held off until the end
        ticks = 0;
        @(posedge clk);
        sample_data <= 16'h1234;
        wr(ADCSQ_OFF_CMD, 8'h01);
        wait_on(1'b1, 10, "start");
        rd(ADCSQ_OFF_CMD, d);
        chk(d[0], 16'h0001, "start bit busy");
        wr(ADCSQ_OFF_PLUS, 8'h05);
        repeat (2) @(posedge clk);
        #1 chk(mux.plus_sel, 16'h0003, "selection held");
        wait_on(1'b0, 100, "finish");
        chk(16'(ticks), ADCSQ_BASE_SAMP + ADCSQ_CONV_CYC, "base length");
        rd(ADCSQ_OFF_CMD, d);
        chk(d[0], 16'h0000, "start bit cleared");
        repeat (2) @(posedge clk);
        #1 chk(mux.plus_sel, 16'h0005, "selection applied");
        rd(ADCSQ_OFF_FLAG, d);
        chk(d, 16'h0001, "ready flag");
        chk(irq, 16'h0001, "irq raised");
        rd(ADCSQ_OFF_VALL, d);
        chk(d, 16'h0034, "value low");
        rd(ADCSQ_OFF_LATCH, d);
        chk(d, 16'h0012, "latched high");
        rd(ADCSQ_OFF_VALH, d);
        chk(d, 16'h0012, "value high");
        rd(ADCSQ_OFF_FLAG, d);
        chk(d, 16'h0000, "read clears");
        chk(irq, 16'h0000, "irq dropped");
        // extended sampling, write-zero and write-one on the flag
        wr(ADCSQ_OFF_SAMP, 8'h03);
        ticks = 0;
        conv(16'h0001);
        chk(16'(ticks), 16'(ADCSQ_BASE_SAMP + ADCSQ_CONV_CYC + 3), "extended length");
        wr(ADCSQ_OFF_FLAG, 8'h00);
        rd(ADCSQ_OFF_FLAG, d);
        chk(d, 16'h0001, "zero write keeps");
        wr(ADCSQ_OFF_FLAG, 8'h01);
        rd(ADCSQ_OFF_FLAG, d);
        chk(d, 16'h0000, "one write clears");
        wr(ADCSQ_OFF_SAMP, 8'h00);
        // window modes against bounds 1000 and 2000, only window irq enabled
        wr(ADCSQ_OFF_LOWL, 8'h00);
        wr(ADCSQ_OFF_LOWL + 5'h01, 8'h10);
        wr(ADCSQ_OFF_HIGHL, 8'h00);
        wr(ADCSQ_OFF_HIGHL + 5'h01, 8'h20);
        wr(ADCSQ_OFF_IEN, 8'h02);
        for (int m = 0; m < 5; m++) begin
            for (int k = 0; k < 4; k++) begin
                wr(ADCSQ_OFF_MODE, {1'b0, 3'(m), 4'h0});
                conv(smp[k]);
                rd(ADCSQ_OFF_FLAG, d);
                chk(d[1], win_exp(m, smp[k]), "window flag");
                chk(irq, win_exp(m, smp[k]), "masked irq");
                rd(ADCSQ_OFF_VALL, d);
                rd(ADCSQ_OFF_FLAG, d);
                chk(d, 16'h0000, "window read clear");
            end
        end
        // zero command does nothing, stop beats start
        wr(ADCSQ_OFF_MODE, 8'h00);
        wr(ADCSQ_OFF_CMD, 8'h01);
        wait_on(1'b1, 10, "start");
        wr(ADCSQ_OFF_CMD, 8'h00);
        #1 chk(conv_active, 16'h0001, "zero command");
        wr(ADCSQ_OFF_CMD, 8'h03);
        wait_on(1'b0, 4, "stop");
        rd(ADCSQ_OFF_CMD, d);
        chk(d[0], 16'h0000, "stopped");
        // start written while busy runs a second conversion
        ticks = 0;
        wr(ADCSQ_OFF_CMD, 8'h01);
        wait_on(1'b1, 10, "start");
        wr(ADCSQ_OFF_CMD, 8'h01);
        wait_on(1'b0, 100, "first finish");
        wait_on(1'b1, 10, "queued begins");
        wait_on(1'b0, 100, "queued finish");
        chk(16'(ticks), 2 * (ADCSQ_BASE_SAMP + ADCSQ_CONV_CYC), "queued start");
        // continuous mode waits for the first start, then chains
        wr(ADCSQ_OFF_MODE, 8'h01);
        repeat (10) @(posedge clk);
        #1 chk(conv_active, 16'h0000, "no start yet");
        ticks = 0;
        wr(ADCSQ_OFF_CMD, 8'h01);
        repeat (90) @(posedge clk);
        #1 chk(16'(ticks > 2 * 14), 16'h0001, "chained");
        wr(ADCSQ_OFF_CMD, 8'h02);
        wait_on(1'b0, 4, "stop chain");
        wr(ADCSQ_OFF_MODE, 8'h00);
        rd(ADCSQ_OFF_VALL, d);
        // event edge only counts when enabled
        @(posedge clk);
        event_in <= 1'b1;
        repeat (8) @(posedge clk);
        event_in <= 1'b0;
        #1 chk(conv_active, 16'h0000, "event ignored");
        wr(ADCSQ_OFF_EVT, 8'h01);
        event_in <= 1'b1;
        wait_on(1'b1, 10, "event start");
        @(posedge clk);
        event_in <= 1'b0;
        wait_on(1'b0, 100, "event finish");
        rd(ADCSQ_OFF_VALL, d);
        // halted without bypass pauses, with bypass runs
        for (int b = 0; b < 2; b++) begin
            wr(ADCSQ_OFF_HALT, {7'h00, b[0]});
            cpu_halted <= 1'b1;
            wr(ADCSQ_OFF_CMD, 8'h01);
            repeat (60) @(posedge clk);
            rd(ADCSQ_OFF_FLAG, d);
            chk(d, {15'h0000, b[0]}, "halt behaviour");
            @(posedge clk);
            cpu_halted <= 1'b0;
            repeat (60) @(posedge clk);
            rd(ADCSQ_OFF_FLAG, d);
            chk(d[0], 16'h0001, "resumed");
            rd(ADCSQ_OFF_VALL, d);
        end
        test_done();
    end
endmodule // adc_sequencing_and_flags_test
